// ===== verilog/sld_top.sv
/*
  segment display driver control: control registers, display ram of one
  nibble per segment, frame timing and drive level generation.
  assumes a single ref_clk domain; sub_osc_clock arrives asynchronously
  and is far slower than ref_clk; an analog stage turns level codes into
  panel voltages.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sld_cfg.svh"

module sld_top
  import sld_pkg::*;
#(
  parameter int SEG_NUM = 32,
  parameter int COM_NUM = 4
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_b,
  input  wire sld_bus_req_s              bus_req,
  output logic     [7:0]                 rd_data,
  input  wire logic                      sub_osc_clock,
  output sld_lvl_t [COM_NUM-1:0]         com_lvl,
  output sld_lvl_t [SEG_NUM-1:0]         seg_lvl,
  output logic                           booster_clk
);

  // sub-oscillator synchroniser and accepted level
  logic       sync1_ff;
  logic       sync2_ff;
  logic       sync3_ff;
  logic       sub_lvl_ff;
  logic       nxt_sub_lvl;
  logic       sub_tick;

  // software visible state
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [4:0] addr_ff;
  logic [4:0] nxt_addr;
  logic [1:0] bf_ff;
  logic [1:0] nxt_bf;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  logic [3:0] ram_ff [SEG_NUM];

  // decoded control
  logic       drv_en;
  logic       bias_third;
  logic       wave_b;
  sld_duty_e  duty;
  logic [1:0] com_last;
  logic [8:0] slot_len;
  logic       wr_data;

  // frame state and level set of the current half slot
  logic [1:0] slot_idx;
  logic       half;
  logic       frame_phase;
  logic       pol;
  sld_lvl_t   lvl_max;
  sld_lvl_t   lvl_com_sel;
  sld_lvl_t   lvl_com_non;
  sld_lvl_t   lvl_seg_on;
  sld_lvl_t   lvl_seg_off;

  // three-stage capture; only the agreed pair of later stages is used
  always_comb begin
    nxt_sub_lvl = sub_lvl_ff;
    sub_tick    = 1'b0;
    if (sync2_ff == sync3_ff) begin
      nxt_sub_lvl = sync3_ff;
      sub_tick    = sync3_ff & ~sub_lvl_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff   <= 1'b0;
      sync2_ff   <= 1'b0;
      sync3_ff   <= 1'b0;
      sub_lvl_ff <= 1'b0;
    end else begin
      sync1_ff   <= sub_osc_clock;
      sync2_ff   <= sync1_ff;
      sync3_ff   <= sync2_ff;
      sub_lvl_ff <= nxt_sub_lvl;
    end
  end

  // register writes and registered read answer
  always_comb begin
    nxt_ctrl    = ctrl_ff;
    nxt_addr    = addr_ff;
    nxt_bf      = bf_ff;
    nxt_rd_data = 8'h00;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `SLD_OFS_CTRL:  nxt_ctrl = bus_req.wdata & `SLD_CTRL_MASK;
        `SLD_OFS_ADDR:  nxt_addr = bus_req.wdata[4:0];
        `SLD_OFS_BOOST: nxt_bf   = {bus_req.wdata[`SLD_BIT_BF_HI],
                                    bus_req.wdata[`SLD_BIT_BF_LO]};
        default:        nxt_ctrl = ctrl_ff;
      endcase
    end
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `SLD_OFS_CTRL:  nxt_rd_data = ctrl_ff;
        `SLD_OFS_ADDR:  nxt_rd_data = {3'h0, addr_ff};
        `SLD_OFS_DATA:  nxt_rd_data = {4'h0, ram_ff[addr_ff]};
        `SLD_OFS_BOOST: nxt_rd_data = {5'h00, bf_ff, 1'b0};
        default:        nxt_rd_data = 8'h00; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff    <= `SLD_RST_CTRL;
      addr_ff    <= `SLD_RST_ADDR;
      bf_ff      <= `SLD_RST_BF;
      rd_data_ff <= 8'h00;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      addr_ff    <= nxt_addr;
      bf_ff      <= nxt_bf;
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;
  assign wr_data = bus_req.wr && (bus_req.addr == `SLD_OFS_DATA);

  // control decode
  always_comb begin
    drv_en     = ctrl_ff[`SLD_BIT_EN];
    bias_third = ctrl_ff[`SLD_BIT_BIAS];
    wave_b     = ctrl_ff[`SLD_BIT_TYPE];
    if (ctrl_ff[`SLD_BIT_DUTY_HI]) begin
      duty = SLD_DUTY_QUARTER;
    end else if (ctrl_ff[`SLD_BIT_DUTY_LO]) begin
      duty = SLD_DUTY_THIRD;
    end else begin
      duty = SLD_DUTY_HALF;
    end
    com_last = 2'h1;
    slot_len = `SLD_DIV_F0_D2;
    unique case (duty)
      SLD_DUTY_HALF: begin
        com_last = 2'h1;
        unique case ({ctrl_ff[`SLD_BIT_FRM_HI], ctrl_ff[`SLD_BIT_FRM_LO]})
          2'h0: slot_len = `SLD_DIV_F0_D2;
          2'h1: slot_len = `SLD_DIV_F1_D2;
          2'h2: slot_len = `SLD_DIV_F2_D2;
          2'h3: slot_len = `SLD_DIV_F3_D2;
        endcase
      end
      SLD_DUTY_THIRD: begin
        com_last = 2'h2;
        unique case ({ctrl_ff[`SLD_BIT_FRM_HI], ctrl_ff[`SLD_BIT_FRM_LO]})
          2'h0: slot_len = `SLD_DIV_F0_D3;
          2'h1: slot_len = `SLD_DIV_F1_D3;
          2'h2: slot_len = `SLD_DIV_F2_D3;
          2'h3: slot_len = `SLD_DIV_F3_D3;
        endcase
      end
      SLD_DUTY_QUARTER: begin
        com_last = 2'h3;
        unique case ({ctrl_ff[`SLD_BIT_FRM_HI], ctrl_ff[`SLD_BIT_FRM_LO]})
          2'h0: slot_len = `SLD_DIV_F0_D4;
          2'h1: slot_len = `SLD_DIV_F1_D4;
          2'h2: slot_len = `SLD_DIV_F2_D4;
          2'h3: slot_len = `SLD_DIV_F3_D4;
        endcase
      end
    endcase
  end

  // frame timer only advances on sub-oscillator ticks
  sld_frame_timer u_frame (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .run         (drv_en),
    .tick        (sub_tick),
    .slot_len    (slot_len),
    .com_last    (com_last),
    .slot_idx    (slot_idx),
    .half        (half),
    .frame_phase (frame_phase)
  );

  sld_booster_div u_boost (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .run       (drv_en),
    .tick      (sub_tick),
    .sub_lvl   (sub_lvl_ff),
    .sel       (bf_ff),
    .boost_clk (booster_clk)
  );

  // type a inverts inside each slot, type b once per frame;
  // both keep the panel free of a net dc term over two frames
  always_comb begin
    pol         = wave_b ? frame_phase : half;
    lvl_max     = bias_third ? 2'h3 : 2'h2;
    lvl_com_sel = pol ? 2'h0 : lvl_max;
    lvl_com_non = pol ? lvl_max - 2'h1 : 2'h1;
    lvl_seg_on  = pol ? lvl_max : 2'h0;
    lvl_seg_off = pol ? lvl_max - 2'h2 : 2'h2;
  end

  // common outputs; commons beyond the duty stay non-selected
  genvar gc;
  generate
    for (gc = 0; gc < COM_NUM; gc++) begin : g_com
      sld_lvl_t com_ff;
      sld_lvl_t nxt_com;
      always_comb begin
        nxt_com = 2'h0;
        if (drv_en) begin
          nxt_com = (slot_idx == 2'(gc)) ? lvl_com_sel : lvl_com_non;
        end
      end
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          com_ff <= 2'h0;
        end else begin
          com_ff <= nxt_com;
        end
      end
      assign com_lvl[gc] = com_ff;
    end
  endgenerate

  // per segment: ram nibble and segment output
  genvar gs;
  generate
    for (gs = 0; gs < SEG_NUM; gs++) begin : g_seg
      logic [3:0] nxt_nib;
      sld_lvl_t   seg_ff;
      sld_lvl_t   nxt_seg;
      always_comb begin
        nxt_nib = ram_ff[gs];
        if (wr_data && (addr_ff == 5'(gs))) begin
          nxt_nib = bus_req.wdata[3:0];
        end
        nxt_seg = 2'h0;
        if (drv_en) begin
          nxt_seg = ram_ff[gs][slot_idx] ? lvl_seg_on : lvl_seg_off;
        end
      end
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          ram_ff[gs] <= `SLD_RST_NIBBLE;
          seg_ff     <= 2'h0;
        end else begin
          ram_ff[gs] <= nxt_nib;
          seg_ff     <= nxt_seg;
        end
      end
      assign seg_lvl[gs] = seg_ff;
    end
  endgenerate

endmodule

`default_nettype wire

// ===== verilog/sld_cfg.svh
/*
  register offsets, field positions, reset values and frame divisors
  of the segment display driver control block.
  assumes inclusion by bare name from the top module, the checker and the testbench.
*/
`ifndef SLD_CFG_SVH
`define SLD_CFG_SVH

// register byte offsets on the plain register port
`define SLD_OFS_CTRL   8'h09
`define SLD_OFS_ADDR   8'h0a
`define SLD_OFS_DATA   8'h0b
`define SLD_OFS_BOOST  8'h0d

// display_control field positions
`define SLD_BIT_BIAS     7
`define SLD_BIT_DUTY_HI  6
`define SLD_BIT_DUTY_LO  5
`define SLD_BIT_EN       4
`define SLD_BIT_TYPE     2
`define SLD_BIT_FRM_HI   1
`define SLD_BIT_FRM_LO   0
// bit 3 is unused and reads as zero
`define SLD_CTRL_MASK    8'hf7

// system_booster_control field positions
`define SLD_BIT_BF_HI    2
`define SLD_BIT_BF_LO    1

// reset values
`define SLD_RST_CTRL   8'h00
`define SLD_RST_ADDR   5'h00
`define SLD_RST_BF     2'h0
`define SLD_RST_NIBBLE 4'h0

// sub-oscillator ticks per common slot, by frame code and duty
`define SLD_DIV_F0_D2  9'd256
`define SLD_DIV_F0_D3  9'd172
`define SLD_DIV_F0_D4  9'd128
`define SLD_DIV_F1_D2  9'd280
`define SLD_DIV_F1_D3  9'd188
`define SLD_DIV_F1_D4  9'd140
`define SLD_DIV_F2_D2  9'd304
`define SLD_DIV_F2_D3  9'd204
`define SLD_DIV_F2_D4  9'd152
`define SLD_DIV_F3_D2  9'd232
`define SLD_DIV_F3_D3  9'd156
`define SLD_DIV_F3_D4  9'd116

`endif

// ===== verilog/sld_pkg.sv
/*
  types shared by the segment display driver control block.
  assumes sld_cfg.svh sits beside it.
*/
package sld_pkg;

  // one cycle register request from software
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sld_bus_req_s;

  // multiplex mode, one-hot
  typedef enum logic [2:0] {
    SLD_DUTY_HALF    = 3'b001,
    SLD_DUTY_THIRD   = 3'b010,
    SLD_DUTY_QUARTER = 3'b100
  } sld_duty_e;

  // drive level in bias steps, 0 is ground
  typedef logic [1:0] sld_lvl_t;

endpackage

// ===== verilog/sld_frame_timer.sv
/*
  frame timer: counts sub-oscillator ticks per common slot, steps the
  active common and flips the frame phase once per frame.
  assumes tick is a one-cycle pulse on ref_clk per rising sub-oscillator edge.
*/
`timescale 1ns/1ps
`default_nettype none

module sld_frame_timer (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic [8:0] slot_len,
  input  wire logic [1:0] com_last,
  output logic      [1:0] slot_idx,
  output logic            half,
  output logic            frame_phase
);

  logic [8:0] cnt_ff;
  logic [8:0] nxt_cnt;
  logic [1:0] slot_ff;
  logic [1:0] nxt_slot;
  logic       phase_ff;
  logic       nxt_phase;

  // slot and frame stepping; held at zero while stopped
  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_slot  = slot_ff;
    nxt_phase = phase_ff;
    if (!run) begin
      nxt_cnt   = 9'h000;
      nxt_slot  = 2'h0;
      nxt_phase = 1'b0;
    end else if (tick) begin
      if (cnt_ff >= slot_len - 9'd1) begin
        nxt_cnt = 9'h000;
        if (slot_ff >= com_last) begin
          nxt_slot  = 2'h0;
          nxt_phase = ~phase_ff;
        end else begin
          nxt_slot = slot_ff + 2'h1;
        end
      end else begin
        nxt_cnt = cnt_ff + 9'd1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff   <= 9'h000;
      slot_ff  <= 2'h0;
      phase_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      slot_ff  <= nxt_slot;
      phase_ff <= nxt_phase;
    end
  end

  assign slot_idx    = slot_ff;
  assign half        = (cnt_ff >= {1'b0, slot_len[8:1]}); // second half of slot
  assign frame_phase = phase_ff;

endmodule

`default_nettype wire

// ===== verilog/sld_booster_div.sv
/*
  booster clock divider: passes the sub-oscillator level or divides it
  by 4, 8 or 16.
  assumes tick marks each accepted rising edge of sub_lvl.
*/
`timescale 1ns/1ps
`default_nettype none

module sld_booster_div (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic       sub_lvl,
  input  wire logic [1:0] sel,
  output logic            boost_clk
);

  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic       out_ff;
  logic       nxt_out;

  // ripple-free divider; counter msb taps give 50 % duty
  always_comb begin
    nxt_cnt = run ? (tick ? cnt_ff + 4'h1 : cnt_ff) : 4'h0;
    nxt_out = 1'b0;
    unique case (sel)
      2'h0: nxt_out = sub_lvl & run;
      2'h1: nxt_out = cnt_ff[1];
      2'h2: nxt_out = cnt_ff[2];
      2'h3: nxt_out = cnt_ff[3];
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 4'h0;
      out_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  assign boost_clk = out_ff;

endmodule

`default_nettype wire

// ===== sim/sld_top_monitor.sv
/*
  checker for sld_top: read answers, field masks, disabled grounding,
  booster gating and level range under half bias.
  assumes it is bound to sld_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sld_cfg.svh"

module sld_top_monitor
  import sld_pkg::*;
#(
  parameter int SEG_NUM = 32,
  parameter int COM_NUM = 4
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire sld_bus_req_s           bus_req,
  input  wire logic [7:0]             rd_data,
  input  wire logic                   sub_osc_clock,
  input  wire sld_lvl_t [COM_NUM-1:0] com_lvl,
  input  wire sld_lvl_t [SEG_NUM-1:0] seg_lvl,
  input  wire logic                   booster_clk
);
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic       top_lvl;

  // shadow of display_control as software last wrote it
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (bus_req.wr && bus_req.addr == `SLD_OFS_CTRL) begin
      nxt_ctrl = bus_req.wdata;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // any pin at level 3, which half bias never uses
  always_comb begin
    top_lvl = 1'b0;
    for (int i = 0; i < COM_NUM; i++) top_lvl |= (com_lvl[i] == 2'h3);
    for (int i = 0; i < SEG_NUM; i++) top_lvl |= (seg_lvl[i] == 2'h3);
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_rd(logic [7:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  // three cycles cover the two-stage path to the booster clock flop
  sequence s_off;
    (!ctrl_ff[`SLD_BIT_EN]) [*3];
  endsequence
  sequence s_half;
    (!ctrl_ff[`SLD_BIT_BIAS]) [*4];
  endsequence

  a_rd_idle_zero: assert property (!bus_req.rd ##1 1'b1 |-> rd_data == 8'h00)
    else $error("read data not zero outside an answer");
  a_ctrl_readback: assert property (s_rd(`SLD_OFS_CTRL) ##1 1'b1 |-> rd_data == (ctrl_ff & `SLD_CTRL_MASK))
    else $error("control readback wrong");
  a_addr_hi_zero: assert property (s_rd(`SLD_OFS_ADDR) ##1 1'b1 |-> rd_data[7:5] == 3'h0)
    else $error("address upper bits not zero");
  a_data_hi_zero: assert property (s_rd(`SLD_OFS_DATA) ##1 1'b1 |-> rd_data[7:4] == 4'h0)
    else $error("data upper bits not zero");
  a_boost_bits: assert property (s_rd(`SLD_OFS_BOOST) ##1 1'b1 |-> (rd_data & 8'hf9) == 8'h00)
    else $error("booster register stray bits");
  a_unmapped_zero: assert property (bus_req.rd && !(bus_req.addr inside {8'h09, 8'h0a, 8'h0b, 8'h0d})
    ##1 1'b1 |-> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_off_ground: assert property (s_off |-> com_lvl == '0 && seg_lvl == '0)
    else $error("outputs not grounded while disabled");
  a_off_boost: assert property (s_off |-> !booster_clk)
    else $error("booster clock runs while disabled");
  a_half_range: assert property (s_half |-> !top_lvl)
    else $error("level 3 under half bias");
endmodule

bind sld_top sld_top_monitor #(.SEG_NUM(SEG_NUM), .COM_NUM(COM_NUM)) u_mon (
  .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
  .sub_osc_clock(sub_osc_clock), .com_lvl(com_lvl), .seg_lvl(seg_lvl),
  .booster_clk(booster_clk));

`default_nettype wire

// ===== sim/sld_panel_model.sv
/*
  glass panel model: keeps the highest drive level seen on any pin since
  the last clear. assumes levels are settled at ref_clk edges.
*/
`timescale 1ns/1ps
`default_nettype none

module sld_panel_model
  import sld_pkg::*;
#(
  parameter int SEG_NUM = 32,
  parameter int COM_NUM = 4
) (
  input  wire logic                   ref_clk,
  input  wire logic                   clr,
  input  wire sld_lvl_t [COM_NUM-1:0] com_lvl,
  input  wire sld_lvl_t [SEG_NUM-1:0] seg_lvl,
  output logic     [1:0]              peak_lvl
);
  logic [1:0] hi;

  // glass sees only voltage, so the peak tells which bias is in use
  always_comb begin
    hi = peak_lvl;
    for (int i = 0; i < COM_NUM; i++) if (com_lvl[i] > hi) hi = com_lvl[i];
    for (int i = 0; i < SEG_NUM; i++) if (seg_lvl[i] > hi) hi = seg_lvl[i];
  end
  always_ff @(posedge ref_clk) peak_lvl <= clr ? 2'h0 : hi;
endmodule

`default_nettype wire

// ===== sim/test_sld_top.sv
/*
  testbench for sld_top: register map, display ram, frame and booster
  timing, bias and disable. assumes sub clock of 8 ref_clk periods.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sld_cfg.svh"

module test_sld_top
  import sld_pkg::*;
;
  logic            ref_clk = 1'b0;
  logic            rst_b = 1'b0;
  logic            sub_osc = 1'b0;
  logic            clr = 1'b0;
  sld_bus_req_s    req = '0;
  logic [7:0]      rd_data;
  sld_lvl_t [3:0]  com_lvl;
  sld_lvl_t [31:0] seg_lvl;
  logic            booster_clk;
  logic [1:0]      peak_lvl;
  int              err_total = 0;
  int              checks_done = 0;
  int              n;
  logic            moved;
  logic [7:0]      ofs [5] = '{8'h09, 8'h0a, 8'h0b, 8'h0d, 8'h0c};
  logic [7:0]      msk [5] = '{8'hf7, 8'h1f, 8'h0f, 8'h06, 8'h00};
  logic [15:0]     divq [4] = '{16'd128, 16'd140, 16'd152, 16'd116};

  always #50 ref_clk = ~ref_clk;
  // offset keeps sub edges away from ref_clk rising edges
  initial begin
    #13;
    forever #400 sub_osc = ~sub_osc;
  end

  sld_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .bus_req(req), .rd_data(rd_data),
    .sub_osc_clock(sub_osc), .com_lvl(com_lvl), .seg_lvl(seg_lvl), .booster_clk(booster_clk));
  sld_panel_model glass (.ref_clk(ref_clk), .clr(clr), .com_lvl(com_lvl), .seg_lvl(seg_lvl),
    .peak_lvl(peak_lvl));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    chk({8'h00, rd_data}, {8'h00, exp});
  endtask
  // com0 selected shows as 3 or 0 under third bias
  task automatic wait_sel(input logic want);
    logic [1:0] first;
    first = com_lvl[0];
    n = 0;
    moved = 1'b0;
    while (((com_lvl[0] == 2'h3) || (com_lvl[0] == 2'h0)) !== want && n < 20000) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (com_lvl[0] !== first && ((com_lvl[0] == 2'h3) || (com_lvl[0] == 2'h0)) !== want)
        moved = 1'b1;
    end
  endtask
  task automatic frame(input logic [7:0] ctl, input logic [15:0] div, input logic [15:0] duty,
                       input logic mv);
    logic [15:0] len;
    wr(`SLD_OFS_CTRL, ctl);
    wait_sel(1'b0);
    wait_sel(1'b1);
    wait_sel(1'b0);
    len = n[15:0];
    chk(len, div * 16'd8);
    chk({15'h0, moved}, {15'h0, mv});
    wait_sel(1'b1);
    chk(len + n[15:0], div * duty * 16'd8);
  endtask
  task automatic rise();
    while (booster_clk !== 1'b0 && n < 500) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (booster_clk !== 1'b1 && n < 500) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog: tests need about 60000 cycles; gives up at 90000
  initial begin
    #9000000;
    err_total++;
    $display("unexpected at %0t: run did not finish", $time);
    conclude();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    // reset values, stored bits, unmapped place
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], 8'h00);
      wr(ofs[i], 8'hff);
      rd(ofs[i], msk[i]);
    end
    $display("test registers done");
    for (int a = 0; a < 32; a++) begin
      wr(`SLD_OFS_ADDR, 8'he0 | a[7:0]);
      wr(`SLD_OFS_DATA, {4'hf, a[3:0] ^ {4{a[4]}}});
    end
    for (int a = 0; a < 32; a++) begin
      wr(`SLD_OFS_ADDR, a[7:0]);
      rd(`SLD_OFS_DATA, {4'h0, a[3:0] ^ {4{a[4]}}});
      rd(`SLD_OFS_DATA, {4'h0, a[3:0] ^ {4{a[4]}}});
      rd(`SLD_OFS_ADDR, a[7:0]);
    end
    $display("test display ram done");
    for (int f = 0; f < 4; f++) begin
      frame({1'b1, (f == 3) ? 2'b11 : 2'b10, 3'b101, f[1:0]}, divq[f], 16'd4, 1'b0);
    end
    frame(8'h94, 16'd256, 16'd2, 1'b0);
    frame(8'hb0, 16'd172, 16'd3, 1'b1);
    $display("test frame timing done");
    for (int b = 0; b < 4; b++) begin
      wr(`SLD_OFS_BOOST, {5'h00, b[1:0], 1'b0});
      // the first rise may come from the switch itself, so skip two
      n = 0;
      rise();
      rise();
      n = 0;
      rise();
      chk(n[15:0], (b == 0) ? 16'd8 : 16'd8 << (b + 1));
    end
    $display("test booster done");
    for (int s = 0; s < 2; s++) begin
      wr(`SLD_OFS_CTRL, {s[0], 7'h54});
      repeat (10) @(posedge ref_clk);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      repeat (1100) @(posedge ref_clk);
      chk({14'h0, peak_lvl}, s[0] ? 16'd3 : 16'd2);
    end
    // nibble bit n drives its segment only while common n is selected
    wait_sel(1'b1);
    chk({14'h0, seg_lvl[1]}, {14'h0, 2'h3 - com_lvl[0]});
    chk({14'h0, seg_lvl[2]}, {14'h0, (com_lvl[0] == 2'h3) ? 2'h2 : 2'h1});
    wait_sel(1'b0);
    chk({14'h0, seg_lvl[2]}, {14'h0, 2'h3 - com_lvl[1]});
    wr(`SLD_OFS_CTRL, 8'hd4);
    wr(`SLD_OFS_CTRL, 8'h00);
    clr <= 1'b1;
    repeat (3) @(posedge ref_clk);
    clr <= 1'b0;
    repeat (300) @(posedge ref_clk);
    chk({14'h0, peak_lvl}, 16'h0);
    chk({15'h0, booster_clk}, 16'h0);
    $display("test bias and disable done");
    conclude();
  end
endmodule

`default_nettype wire
